/* File: dv/mram_mapper_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module mram_mapper_asserts
   import mram_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Settings and requests
   input wire logic [2:0] pendingMode,
   input wire logic pendingOrder,
   input wire logic [15:0] pendingAct2Source,
   input wire logic validate,
   input wire logic reqValid,
   // Results
   input wire logic paramAccess,
   input wire logic paramIs32,
   input wire logic paramHighWord,
   input wire logic unmappedAddr,
   input wire logic paramDataValid,
   input wire logic [31:0] paramData,
   input wire logic regValid,
   input wire logic [15:0] regData,
   input wire logic [7:0] regByteFirst,
   input wire logic [7:0] regByteSecond,
   input wire mram_mode_t activeMode,
   input wire mram_order_t activeOrder,
   input wire logic [15:0] secondActualPassthroughSource
);
   logic up;
   logic [15:0] expWord;

   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);

   // Marks cycles after the restart load and keeps the word the store value should yield.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         up <= 1'b0;
         expWord <= 16'h0000;
      end else begin
         up <= 1'b1;
         expWord <= (paramHighWord && paramIs32) ? paramData[31:16] : paramData[15:0];
      end
   end

   AST_ONE_ANSWER: assert property (reqValid |=> paramAccess ^ unmappedAddr)
      else $error("request not answered by one strobe");
   AST_NO_STROBE: assert property (!reqValid |=> !paramAccess && !unmappedAddr)
      else $error("strobe without request");
   AST_HOLD: assert property (up && !validate
      |=> $stable(activeMode) && $stable(activeOrder))
      else $error("settings changed without validate");
   AST_MODE: assert property (validate && pendingMode <= 3'h5
      |=> activeMode == $past(pendingMode))
      else $error("mode not applied");
   AST_ORDER: assert property (validate |=> activeOrder == $past(pendingOrder))
      else $error("order not applied");
   AST_BYTES: assert property (regValid
      |-> regByteFirst == regData[15:8] && regByteSecond == regData[7:0])
      else $error("byte order wrong");
   AST_WORD: assert property (paramDataValid |=> regValid && regData == expWord)
      else $error("register word wrong");
   AST_LOW16: assert property (paramAccess && !paramIs32 |-> !paramHighWord)
      else $error("high word on 16-bit view");
   AST_SOURCE: assert property (up
      |=> secondActualPassthroughSource == $past(pendingAct2Source))
      else $error("source not followed");
endmodule

////////////////////////////////////////////////////////////
bind mram_mapper mram_mapper_asserts i_mram_mapper_asserts (.clock(clock), .nrst(nrst),
   .pendingMode(pendingMode), .pendingOrder(pendingOrder), .pendingAct2Source(pendingAct2Source),
   .validate(validate), .reqValid(reqValid), .paramAccess(paramAccess), .paramIs32(paramIs32),
   .paramHighWord(paramHighWord), .unmappedAddr(unmappedAddr), .paramDataValid(paramDataValid),
   .paramData(paramData), .regValid(regValid), .regData(regData), .regByteFirst(regByteFirst),
   .regByteSecond(regByteSecond), .activeMode(activeMode), .activeOrder(activeOrder),
   .secondActualPassthroughSource(secondActualPassthroughSource));

`default_nettype wire

/* File: dv/mram_mapper_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module mram_mapper_tb_top
   import mram_pkg::*;
;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [2:0] pendingMode = 3'h0;
   logic pendingOrder = 1'h1;
   logic [15:0] pendingAct2Source = 16'h0000;
   logic validate = 1'b0;
   logic reqValid = 1'b0;
   logic [19:0] reqAddr = 20'h00000;
   logic slow = 1'b0;
   logic paramAccess, paramIs32, paramHighWord, unmappedAddr, paramDataValid, regValid;
   logic [7:0] paramGroup, paramIndex, regByteFirst, regByteSecond;
   logic [31:0] paramData;
   logic [15:0] regData, secondActualPassthroughSource;
   mram_mode_t activeMode;
   mram_order_t activeOrder;
   int n_errors = 0;
   int checks_done = 0;
   int curMode = 0;
   int curOrder = 1;
   logic [31:0] seed = 32'hB5CB;
   int gLo[6] = '{1, 1, 1, 1, 128, 1};
   int gHi[6] = '{99, 255, 127, 255, 254, 255};
   int iLo[6] = '{1, 1, 1, 1, 1, 128};
   int iHi[6] = '{99, 255, 255, 127, 255, 254};
   // Register words the model expects, oldest first.
   int expWords[$];

   mram_mapper i_mram_mapper (.clock(clock), .nrst(nrst), .pendingMode(pendingMode),
      .pendingOrder(pendingOrder), .pendingAct2Source(pendingAct2Source), .validate(validate),
      .reqValid(reqValid), .reqAddr(reqAddr), .paramAccess(paramAccess), .paramGroup(paramGroup),
      .paramIndex(paramIndex), .paramIs32(paramIs32), .paramHighWord(paramHighWord),
      .unmappedAddr(unmappedAddr), .paramDataValid(paramDataValid), .paramData(paramData),
      .regValid(regValid), .regData(regData), .regByteFirst(regByteFirst),
      .regByteSecond(regByteSecond), .activeMode(activeMode), .activeOrder(activeOrder),
      .secondActualPassthroughSource(secondActualPassthroughSource));

   mram_store_model i_mram_store_model (.clock(clock), .nrst(nrst), .slow(slow),
      .paramAccess(paramAccess), .paramGroup(paramGroup), .paramIndex(paramIndex),
      .paramDataValid(paramDataValid), .paramData(paramData));

   ////////////////////////////////////////////////////////////
   // Free-running clock.
   always #5 clock = ~clock;

   function automatic logic [31:0] lfsr();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   // Expected register address of a parameter view in a mode.
   function automatic int adr(int m, bit w, int g, int i);
      case (m)
         0: return w ? 420000 + 200 * g + 2 * i : 400000 + 100 * g + i;
         1: return 400000 + 256 * g + i;
         2, 4: return 400000 + 512 * g + 2 * i;
         default: return 400000 + 256 * g + 2 * i;
      endcase
   endfunction

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic final_report();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Changes pending settings, shows they wait for validate, then applies them.
   task automatic apply(input int m, input int o);
      @(posedge clock);
      #1 pendingMode = 3'(m);
      pendingOrder = o[0];
      pendingAct2Source = 16'(lfsr());
      repeat (2) @(posedge clock);
      #1 chk(activeMode, curMode);
      chk(activeOrder, curOrder);
      validate = 1'b1;
      @(posedge clock);
      #1 validate = 1'b0;
      if (m < 6) curMode = m;
      curOrder = o;
      chk(activeMode, curMode);
      chk(activeOrder, curOrder);
      chk(secondActualPassthroughSource, pendingAct2Source);
   endtask

   // Issues one request and follows it through to the register word.
   task automatic req(input int a, input bit hit, input int g, input int i, input bit w,
      input bit s);
      logic [31:0] d;
      logic [15:0] wd;
      d = lfsr();
      @(posedge clock);
      #1 reqValid = 1'b1;
      reqAddr = a[19:0];
      slow = d[0];
      @(posedge clock);
      #1 reqValid = 1'b0;
      chk(unmappedAddr, !hit);
      chk(paramAccess, hit);
      if (hit) begin
         chk(paramGroup, g[7:0]);
         chk(paramIndex, i[7:0]);
         chk({paramIs32, paramHighWord}, {w, w && s == curOrder});
         d = {g[7:0], i[7:0], ~g[7:0], ~i[7:0]};
         expWords.push_back((w && s == curOrder) ? d[31:16] : d[15:0]);
         for (int k = 0; k < 5 && regValid !== 1'b1; k++) @(posedge clock) #1;
         wd = 16'(expWords.pop_front());
         chk(regValid, 1);
         chk(regData, wd);
         chk({regByteFirst, regByteSecond}, wd);
      end
   endtask

   // Main sequence: reset values, every mode in both word orders, unmapped addresses.
   initial begin
      int g, i;
      bit w, s;
      repeat (20) @(posedge clock);
      chk(activeMode, 0);
      chk(activeOrder, 1);
      chk(secondActualPassthroughSource, 0);
      #1 nrst = 1'b1;
      for (int m = 0; m < 6; m++) begin
         for (int o = 0; o < 2; o++) begin
            apply(m, o);
            repeat (6) begin
               g = gLo[m] + lfsr() % (gHi[m] - gLo[m] + 1);
               i = iLo[m] + lfsr() % (iHi[m] - iLo[m] + 1);
               w = (m > 1) || (m == 0 && lfsr() % 2 == 1);
               s = w && (lfsr() % 2 == 1);
               req(adr(m, w, g, i) + s, 1, g, i, w, s);
            end
            req(adr(m, 0, 1, m == 5 ? 127 : 0), 0, 0, 0, 0, 0);
            req(399999, 0, 0, 0, 0, 0);
         end
      end
      apply(6, 0);
      // A restart takes pending settings that were never validated.
      pendingMode = 3'h2;
      nrst = 1'b0;
      @(posedge clock);
      #1 chk(activeMode, 0);
      chk(activeOrder, 1);
      nrst = 1'b1;
      repeat (2) @(posedge clock);
      #1 chk(activeMode, 2);
      chk(activeOrder, 0);
      curMode = 2;
      curOrder = 0;
      req(adr(2, 1, 5, 7) + 1, 1, 5, 7, 1, 1);
      final_report();
   end

   // Cuts a hang short.
   initial begin
      #500000;
      n_errors++;
      final_report();
   end
endmodule

`default_nettype wire

/* File: dv/mram_store_model.sv */
`timescale 1ns/1ps
`default_nettype none

module mram_store_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Answer one cycle later when set
   input wire logic slow,
   // Access from the mapper
   input wire logic paramAccess,
   input wire logic [7:0] paramGroup,
   input wire logic [7:0] paramIndex,
   // Value handed back
   output logic paramDataValid,
   output logic [31:0] paramData
);
   logic pend;

   // Answers an access with a value built from group and index; idle data keeps toggling.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pend <= 1'b0;
         paramDataValid <= 1'b0;
         paramData <= 32'h00000000;
      end else begin
         pend <= paramAccess && slow;
         paramDataValid <= (paramAccess && !slow) || pend;
         paramData <= ((paramAccess && !slow) || pend) ?
            {paramGroup, paramIndex, ~paramGroup, ~paramIndex} : ~paramData;
      end
   end
endmodule

`default_nettype wire

/* File: verilog/mram_defines.svh */
`ifndef MRAM_DEFINES_SVH
`define MRAM_DEFINES_SVH

// Width of a holding-register address as seen by the mapper.
`define MRAM_ADDR_W 20

// Base register of the 16-bit views and of the mode 0 32-bit view.
`define MRAM_BASE16 20'h61A80
`define MRAM_BASE32 20'h668A0

// Spans above a base inside which a mode can hit.
`define MRAM_SPAN0_16 20'h02710
`define MRAM_SPAN0_32 20'h04E20
`define MRAM_SPAN_64K 20'h10000
`define MRAM_SPAN_128K 20'h20000

// Mode 0 strides: 100 registers per group (16-bit), 200 per group (32-bit).
`define MRAM_DIV0_16 15'h0064
`define MRAM_DIV0_32 15'h00C8

// Group and index limits.
`define MRAM_MIN_NUM 8'h01
`define MRAM_MAX0 8'h63
`define MRAM_G4_MIN 8'h80
`define MRAM_G4_MAX 8'hFE
`define MRAM_I5_BASE 8'h80
`define MRAM_I5_MAX 8'hFE
`define MRAM_G5_RAW_MIN 9'h002
`define MRAM_G5_RAW_MAX 9'h100

// Mode codes.
`define MRAM_MODE0 3'h0
`define MRAM_MODE1 3'h1
`define MRAM_MODE2 3'h2
`define MRAM_MODE3 3'h3
`define MRAM_MODE4 3'h4
`define MRAM_MODE5 3'h5

// Word order codes.
`define MRAM_ORDER_HIGH_FIRST 1'h0
`define MRAM_ORDER_LOW_FIRST 1'h1

// Reset values.
`define MRAM_MODE_DEF 3'h0
`define MRAM_ORDER_DEF 1'h1
`define MRAM_ACT2_DEF 16'h0000

`endif

/* File: verilog/mram_mapper.sv */
// How it works
// - Mode setting codes zero to five, reset zero.
// - Mode 0 16-bit: 400000+100*group+index.
// - Mode 0 32-bit: 420000+200*group+2*index.
// - Mode 1 16-bit: 400000+256*group+index.
// - Mode 2 32-bit: 400000+512*group+2*index.
// - Mode 3 32-bit: 400000+256*group+2*index.
// - Mode 4: groups 128-254, 512 stride.
// - Mode 5: indexes 128-254, 256 stride.
// - New mode and word-order settings apply only on restart or validate.
// - High byte of each register goes first.
// - Word order zero puts high word first.
// - Word order one puts low word first, default.
// - Second actual passthrough source, default none.
`timescale 1ns/1ps
`default_nettype none

module mram_mapper
   import mram_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Pending settings from the parameter store
   input wire logic [2:0] pendingMode,
   input wire logic pendingOrder,
   input wire logic [15:0] pendingAct2Source,
   input wire logic validate,
   // Register address request from the Modbus side
   input wire logic reqValid,
   input wire logic [`MRAM_ADDR_W-1:0] reqAddr,
   // Parameter access toward the parameter store
   output logic paramAccess,
   output logic [7:0] paramGroup,
   output logic [7:0] paramIndex,
   output logic paramIs32,
   output logic paramHighWord,
   output logic unmappedAddr,
   // Parameter value returned by the store
   input wire logic paramDataValid,
   input wire logic [31:0] paramData,
   // Register word toward the Modbus side
   output logic regValid,
   output logic [15:0] regData,
   output logic [7:0] regByteFirst,
   output logic [7:0] regByteSecond,
   // Active settings
   output var mram_mode_t activeMode,
   output var mram_order_t activeOrder,
   output logic [15:0] secondActualPassthroughSource
);

   logic loadAtBoot;
   logic applyNow;
   logic [`MRAM_ADDR_W-1:0] off16;
   logic [`MRAM_ADDR_W-1:0] off32;
   logic in16;
   logic in32;
   logic [14:0] quot16;
   logic [14:0] rem16;
   logic [14:0] quot32;
   logic [14:0] rem32;
   logic [8:0] g5Raw;
   mram_map_t map;

   ////////////////////////////////////////////////////////////////////////////
   // Settings
   ////////////////////////////////////////////////////////////////////////////

   // Pending values are taken on the first edge after a restart and on validate.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         loadAtBoot <= 1'b1;
      end else begin
         loadAtBoot <= 1'b0;
      end
   end

   assign applyNow = loadAtBoot || validate;

   // Active mode; an out-of-range pending code leaves the old mode in place.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         activeMode <= mram_mode_t'(`MRAM_MODE_DEF);
      end else if (applyNow && pendingMode <= `MRAM_MODE5) begin
         activeMode <= mram_mode_t'(pendingMode);
      end
   end

   // Active word order; low word first after reset.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         activeOrder <= mram_order_t'(`MRAM_ORDER_DEF);
      end else if (applyNow) begin
         activeOrder <= mram_order_t'(pendingOrder);
      end
   end

   // Source of the second actual value in passthrough; follows the store.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         secondActualPassthroughSource <= `MRAM_ACT2_DEF;
      end else begin
         secondActualPassthroughSource <= pendingAct2Source;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode
   ////////////////////////////////////////////////////////////////////////////

   // Offsets above each base; only meaningful when the address is not below it.
   assign off16 = reqAddr - `MRAM_BASE16;
   assign off32 = reqAddr - `MRAM_BASE32;
   assign in16 = reqAddr >= `MRAM_BASE16;
   assign in32 = reqAddr >= `MRAM_BASE32;

   // Mode 0 needs division by its decimal strides.
   assign quot16 = off16[14:0] / `MRAM_DIV0_16;
   assign rem16 = 15'(off16[14:0] - 15'(quot16 * `MRAM_DIV0_16));
   assign quot32 = off32[14:0] / `MRAM_DIV0_32;
   assign rem32 = 15'(off32[14:0] - 15'(quot32 * `MRAM_DIV0_32));

   // Mode 5 indexes past 127 spill into the next group's stride.
   assign g5Raw = off16[16:8];

   // Turns the address into group, index, width and register half.
   always_comb begin
      map = '0;
      unique case (activeMode)
         MRAM_MODE0: begin
            if (in32 && off32 < `MRAM_SPAN0_32) begin
               map.is32 = 1'b1;
               map.group = quot32[7:0];
               map.index = {1'b0, rem32[7:1]};
               map.second = rem32[0];
            end else if (in16 && off16 < `MRAM_SPAN0_16) begin
               map.group = quot16[7:0];
               map.index = rem16[7:0];
            end
            map.hit = (in16 && off16 < `MRAM_SPAN0_16) || (in32 && off32 < `MRAM_SPAN0_32);
            map.hit = map.hit && map.group >= `MRAM_MIN_NUM && map.group <= `MRAM_MAX0
               && map.index >= `MRAM_MIN_NUM && map.index <= `MRAM_MAX0;
         end
         MRAM_MODE1: begin
            map.group = off16[15:8];
            map.index = off16[7:0];
            map.hit = in16 && off16 < `MRAM_SPAN_64K
               && map.group >= `MRAM_MIN_NUM && map.index >= `MRAM_MIN_NUM;
         end
         MRAM_MODE2: begin
            map.is32 = 1'b1;
            map.group = {1'b0, off16[15:9]};
            map.index = off16[8:1];
            map.second = off16[0];
            map.hit = in16 && off16 < `MRAM_SPAN_64K
               && map.group >= `MRAM_MIN_NUM && map.index >= `MRAM_MIN_NUM;
         end
         MRAM_MODE3: begin
            map.is32 = 1'b1;
            map.group = off16[15:8];
            map.index = {1'b0, off16[7:1]};
            map.second = off16[0];
            map.hit = in16 && off16 < `MRAM_SPAN_64K
               && map.group >= `MRAM_MIN_NUM && map.index >= `MRAM_MIN_NUM;
         end
         MRAM_MODE4: begin
            map.is32 = 1'b1;
            map.group = off16[16:9];
            map.index = off16[8:1];
            map.second = off16[0];
            map.hit = in16 && off16 < `MRAM_SPAN_128K
               && map.group >= `MRAM_G4_MIN && map.group <= `MRAM_G4_MAX
               && map.index >= `MRAM_MIN_NUM;
         end
         MRAM_MODE5: begin
            map.is32 = 1'b1;
            map.group = 8'(g5Raw - 9'h001);
            map.index = 8'(`MRAM_I5_BASE + {1'b0, off16[7:1]});
            map.second = off16[0];
            map.hit = in16 && off16 < `MRAM_SPAN_128K
               && g5Raw >= `MRAM_G5_RAW_MIN && g5Raw <= `MRAM_G5_RAW_MAX
               && map.index <= `MRAM_I5_MAX;
         end
         default: begin
            map = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access outputs
   ////////////////////////////////////////////////////////////////////////////

   // One-cycle strobes: a hit accesses a parameter, a miss only raises the flag.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         paramAccess <= 1'b0;
         unmappedAddr <= 1'b0;
      end else begin
         paramAccess <= reqValid && map.hit;
         unmappedAddr <= reqValid && !map.hit;
      end
   end

   // Group, index and half of the last hit hold until the next hit.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         paramGroup <= 8'h00;
         paramIndex <= 8'h00;
         paramIs32 <= 1'b0;
         paramHighWord <= 1'b0;
      end else if (reqValid && map.hit) begin
         paramGroup <= map.group;
         paramIndex <= map.index;
         paramIs32 <= map.is32;
         // First register carries the high word only in high-word-first order.
         paramHighWord <= map.is32
            && (map.second == (activeOrder == MRAM_LOW_WORD_FIRST));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register word formation
   ////////////////////////////////////////////////////////////////////////////

   // Picks the register's half of the value and orders its bytes.
   mram_reg_former former (
      .clock(clock),
      .nrst(nrst),
      .paramDataValid(paramDataValid),
      .paramData(paramData),
      .is32(paramIs32),
      .highWord(paramHighWord),
      .regValid(regValid),
      .regData(regData),
      .regByteFirst(regByteFirst),
      .regByteSecond(regByteSecond)
   );

endmodule

`default_nettype wire

/* File: verilog/mram_pkg.sv */
`default_nettype none
`include "mram_defines.svh"

package mram_pkg;

   // Addressing modes.
   typedef enum logic [2:0] {
      MRAM_MODE0 = `MRAM_MODE0,
      MRAM_MODE1 = `MRAM_MODE1,
      MRAM_MODE2 = `MRAM_MODE2,
      MRAM_MODE3 = `MRAM_MODE3,
      MRAM_MODE4 = `MRAM_MODE4,
      MRAM_MODE5 = `MRAM_MODE5
   } mram_mode_t;

   // Order of the two registers of a 32-bit parameter.
   typedef enum logic {
      MRAM_HIGH_WORD_FIRST = `MRAM_ORDER_HIGH_FIRST,
      MRAM_LOW_WORD_FIRST = `MRAM_ORDER_LOW_FIRST
   } mram_order_t;

   // Result of decoding one register address.
   typedef struct packed {
      logic hit;
      logic is32;
      logic second;
      logic [7:0] group;
      logic [7:0] index;
   } mram_map_t;

endpackage

`default_nettype wire

/* File: verilog/mram_reg_former.sv */
`timescale 1ns/1ps
`default_nettype none

module mram_reg_former
   import mram_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Parameter value and the half it should yield
   input wire logic paramDataValid,
   input wire logic [31:0] paramData,
   input wire logic is32,
   input wire logic highWord,
   // Register word and its bytes in wire order
   output logic regValid,
   output logic [15:0] regData,
   output logic [7:0] regByteFirst,
   output logic [7:0] regByteSecond
);

   logic [15:0] next_regData;

   ////////////////////////////////////////////////////////////////////////////
   // A 16-bit parameter always travels in the low half of the value.
   always_comb begin
      next_regData = paramData[15:0];
      if (is32 && highWord) begin
         next_regData = paramData[31:16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // One-cycle strobe marking a fresh register word.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regValid <= 1'b0;
      end else begin
         regValid <= paramDataValid;
      end
   end

   // Word and bytes hold until the next value arrives; high byte goes first.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         regData <= 16'h0000;
         regByteFirst <= 8'h00;
         regByteSecond <= 8'h00;
      end else if (paramDataValid) begin
         regData <= next_regData;
         regByteFirst <= next_regData[15:8];
         regByteSecond <= next_regData[7:0];
      end
   end

endmodule

`default_nettype wire
